// ===== include/amcr_pkg.sv
// Package for the audio mode control register bank.
// Assumes a byte-wide register port driven by an I2C slave front end on sys_clk.
`default_nettype none
package amcr_pkg;
    localparam logic [7:0] ADDR_CLK_MODE = 8'h0a;
    localparam logic [7:0] ADDR_FMT_MODE = 8'h0b;
    localparam logic [7:0] ADDR_REVISION = 8'h0c;
    localparam logic [7:0] RST_CLK_MODE = 8'h00;
    localparam logic [7:0] RST_FMT_MODE = 8'h00;
    localparam logic [7:0] RST_RD_DATA = 8'h00;
    // Arbitrary revision value, not tied to any part
    localparam logic [3:0] REVISION_CODE = 4'h5;
    localparam int MCLK_HALVE_BIT = 7;
    localparam int CLOCK_DIVIDE_LSB = 5;
    localparam int SPEED_BIT = 4;
    localparam int FREQ_SHIFT_LSB = 2;
    localparam int DEEMPH_LSB = 0;
    localparam int FMT_LSB = 6;
    localparam int VOLLINK_BIT = 5;
    localparam int BYPASS_BIT = 4;
    localparam int REGCTL_BIT = 3;
    localparam int HOLD_BIT = 2;
    localparam int HPSEN_BIT = 1;

    // Register port request from the control port front end
    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [7:0] addr;
        logic [7:0] wdata;
    } amcr_req_t;

    // Applied configuration seen by the datapath
    typedef struct packed {
        logic [1:0] clockDivideSelect;
        logic doubleSpeedSelect;
        logic [1:0] frequencyShiftSelect;
        logic [1:0] deemphasisSelect;
        logic [1:0] serialFormatSelect;
        logic volumeLink;
        logic volumePathBypass;
        logic registerControlEnable;
        logic trebleAllowed;
        logic rampAllowed;
        logic headphoneSenseEnable;
    } amcr_cfg_t;
endpackage
`default_nettype wire

// ===== hw/amcr_regs.sv
// Mode and clocking register bank with update hold and master clock halving.
// Assumes req arrives synchronous to sys_clk from an I2C slave front end.
`default_nettype none
// Function
// - Setting the halving bit divides the master clock by two before other logic uses it.
// - Speed bit 0 is single speed (8 to 50 kHz), 1 is double speed (50 to 96 kHz).
// - In double speed, de-emphasis, ramp control and treble boost are forced off.
// - De-emphasis 00 off, 01 for 44.1 kHz, 10 for 48 kHz, 11 for 32 kHz.
// - Format 00 I2S, 01 right 16-bit, 10 left-justified, 11 right 24-bit; the source matches it.
// - With volume link set both outputs use the channel A volume byte.
// - With bypass set volume, mute, tone, limiting and mixing are skipped; here volumeOutA and volumeOutB still carry the volume bytes under bypass.
// - The device starts in stand-alone mode; writing 1 to register control hands over to registers.
// - While update hold is set writes are stored but applied only when it clears.
// - The revision register holds a code in its low four bits and zero above.
// - While reset is low all registers return to defaults and accesses are refused.
// - Registers are reached through a two-wire I2C control port clocked by the host.
module amcr_regs (
    input wire logic sys_clk, // Master clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire amcr_pkg::amcr_req_t req, // Register port request from I2C front end
    input wire logic [7:0] volumeByteA, // Channel A volume byte
    input wire logic [7:0] volumeByteB, // Channel B volume byte
    output logic [7:0] rdData, // Read data, registered
    output logic coreClkEn, // Enable marking usable master clock edges
    output amcr_pkg::amcr_cfg_t cfg, // Applied configuration, registered
    output logic [7:0] volumeOutA, // Volume applied to headphone_out_a
    output logic [7:0] volumeOutB // Volume applied to headphone_out_b
);
    logic [7:0] clkMode_ff, nxt_clkMode;
    logic [7:0] fmtMode_ff, nxt_fmtMode;
    logic [7:0] appClk_ff, nxt_appClk;
    logic [7:0] appFmt_ff, nxt_appFmt;
    logic [7:0] rdData_ff, nxt_rdData;
    logic halfPhase_ff, nxt_halfPhase;
    logic holdNow;

    // Write strobe aimed at one register address
    function automatic logic wrHit(input amcr_pkg::amcr_req_t r, input logic [7:0] a);
        return r.wrStb && (r.addr == a);
    endfunction

    // Read strobe aimed at one register address
    function automatic logic rdHit(input amcr_pkg::amcr_req_t r, input logic [7:0] a);
        return r.rdStb && (r.addr == a);
    endfunction

    // Shadow registers take every write
    always_comb begin
        nxt_clkMode = clkMode_ff;
        nxt_fmtMode = fmtMode_ff;
        if (wrHit(req, amcr_pkg::ADDR_CLK_MODE)) begin
            nxt_clkMode = req.wdata;
        end
        if (wrHit(req, amcr_pkg::ADDR_FMT_MODE)) begin
            nxt_fmtMode = {req.wdata[7:1], 1'b0};
        end
    end

    // Applied copy follows shadow unless hold is set
    assign holdNow = fmtMode_ff[amcr_pkg::HOLD_BIT];
    always_comb begin
        nxt_appClk = appClk_ff;
        nxt_appFmt = appFmt_ff;
        if (!holdNow) begin
            nxt_appClk = clkMode_ff;
            nxt_appFmt = fmtMode_ff;
        end
    end

    // Read mux, revision upper nibble zero
    always_comb begin
        nxt_rdData = rdData_ff;
        if (req.rdStb) begin
            unique case (req.addr)
                amcr_pkg::ADDR_CLK_MODE: nxt_rdData = clkMode_ff;
                amcr_pkg::ADDR_FMT_MODE: nxt_rdData = fmtMode_ff;
                amcr_pkg::ADDR_REVISION: nxt_rdData = {4'h0, amcr_pkg::REVISION_CODE};
                default: nxt_rdData = 8'h00;
            endcase
        end
    end

    // Halving toggles each edge when enabled
    always_comb begin
        nxt_halfPhase = 1'b0;
        if (appClk_ff[amcr_pkg::MCLK_HALVE_BIT]) begin
            nxt_halfPhase = ~halfPhase_ff;
        end
    end
    assign coreClkEn = !appClk_ff[amcr_pkg::MCLK_HALVE_BIT] || halfPhase_ff;

    // Shadow registers, defaults on reset so accesses are dropped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkMode_ff <= amcr_pkg::RST_CLK_MODE;
            fmtMode_ff <= amcr_pkg::RST_FMT_MODE;
        end else begin
            clkMode_ff <= nxt_clkMode;
            fmtMode_ff <= nxt_fmtMode;
        end
    end

    // Applied copy, defaults on reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            appClk_ff <= amcr_pkg::RST_CLK_MODE;
            appFmt_ff <= amcr_pkg::RST_FMT_MODE;
        end else begin
            appClk_ff <= nxt_appClk;
            appFmt_ff <= nxt_appFmt;
        end
    end

    // Read data register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_ff <= amcr_pkg::RST_RD_DATA;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    // Halving phase, cleared on reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            halfPhase_ff <= 1'b0;
        end else begin
            halfPhase_ff <= nxt_halfPhase;
        end
    end
    assign rdData = rdData_ff;

    // Decoded fields from applied copy
    logic dbl;
    assign dbl = appClk_ff[amcr_pkg::SPEED_BIT];
    assign cfg.clockDivideSelect = appClk_ff[amcr_pkg::CLOCK_DIVIDE_LSB +: 2];
    assign cfg.doubleSpeedSelect = dbl;
    assign cfg.frequencyShiftSelect = appClk_ff[amcr_pkg::FREQ_SHIFT_LSB +: 2];
    assign cfg.deemphasisSelect = dbl ? 2'h0 : appClk_ff[amcr_pkg::DEEMPH_LSB +: 2];
    assign cfg.trebleAllowed = !dbl;
    assign cfg.rampAllowed = !dbl;
    assign cfg.serialFormatSelect = appFmt_ff[amcr_pkg::FMT_LSB +: 2];
    assign cfg.volumeLink = appFmt_ff[amcr_pkg::VOLLINK_BIT];
    assign cfg.volumePathBypass = appFmt_ff[amcr_pkg::BYPASS_BIT];
    assign cfg.registerControlEnable = appFmt_ff[amcr_pkg::REGCTL_BIT];
    assign cfg.headphoneSenseEnable = appFmt_ff[amcr_pkg::HPSEN_BIT];

    // Volume link selects channel A byte for both outputs
    assign volumeOutA = volumeByteA;
    assign volumeOutB = cfg.volumeLink ? volumeByteA : volumeByteB;

    // Hold keeps the applied copy, release copies the shadow
    chk_hold_blocks_apply: assert property (@(posedge sys_clk) disable iff (!rst_n)
        holdNow |=> $stable(appClk_ff) && $stable(appFmt_ff))
        else $error("applied mode changed under hold");
    chk_release_applies: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !holdNow |=> appFmt_ff == $past(fmtMode_ff) && appClk_ff == $past(clkMode_ff))
        else $error("shadow not applied after hold");
    chk_write_stored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wrHit(req, amcr_pkg::ADDR_CLK_MODE) |=> clkMode_ff == $past(req.wdata))
        else $error("write lost");
    chk_write_fmt_stored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wrHit(req, amcr_pkg::ADDR_FMT_MODE) |=> fmtMode_ff == {$past(req.wdata[7:1]), 1'b0})
        else $error("format write lost");
    chk_rev_write_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wrHit(req, amcr_pkg::ADDR_REVISION) |=> $stable(clkMode_ff) && $stable(fmtMode_ff))
        else $error("revision write changed a register");

    // Speed gating and master clock halving
    chk_double_no_dem: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dbl |-> cfg.deemphasisSelect == 2'h0 && !cfg.trebleAllowed && !cfg.rampAllowed)
        else $error("double speed kept a single speed feature");
    chk_single_dem_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !dbl |-> cfg.deemphasisSelect == appClk_ff[amcr_pkg::DEEMPH_LSB +: 2] && cfg.trebleAllowed && cfg.rampAllowed)
        else $error("single speed features wrong");
    chk_speed_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg.doubleSpeedSelect == appClk_ff[amcr_pkg::SPEED_BIT])
        else $error("speed select mismatch");
    chk_halve_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        appClk_ff[amcr_pkg::MCLK_HALVE_BIT] && $past(appClk_ff[amcr_pkg::MCLK_HALVE_BIT]) && coreClkEn
        |=> !appClk_ff[amcr_pkg::MCLK_HALVE_BIT] || !coreClkEn)
        else $error("halved clock enable not alternating");
    chk_halve_toggles: assert property (@(posedge sys_clk) disable iff (!rst_n)
        appClk_ff[amcr_pkg::MCLK_HALVE_BIT] |=> halfPhase_ff != $past(halfPhase_ff))
        else $error("halving phase stuck");
    chk_full_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !appClk_ff[amcr_pkg::MCLK_HALVE_BIT] |-> coreClkEn)
        else $error("clock enable dropped without halving");

    // Format, control and volume routing
    chk_format_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg.serialFormatSelect == appFmt_ff[amcr_pkg::FMT_LSB +: 2])
        else $error("format select mismatch");
    chk_bypass_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg.volumePathBypass == appFmt_ff[amcr_pkg::BYPASS_BIT])
        else $error("bypass mismatch");
    chk_regctl_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg.registerControlEnable == appFmt_ff[amcr_pkg::REGCTL_BIT])
        else $error("register control mismatch");
    chk_link_vol_b: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg.volumeLink |-> volumeOutB == volumeByteA && volumeOutA == volumeByteA)
        else $error("linked volume wrong");
    chk_unlinked_vol: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !cfg.volumeLink |-> volumeOutB == volumeByteB && volumeOutA == volumeByteA)
        else $error("unlinked volume wrong");

    // Read path
    chk_rev_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rdHit(req, amcr_pkg::ADDR_REVISION) |=> rdData == {4'h0, amcr_pkg::REVISION_CODE})
        else $error("revision read wrong");
    chk_read_clk_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rdHit(req, amcr_pkg::ADDR_CLK_MODE) |=> rdData == $past(clkMode_ff))
        else $error("clock mode read wrong");
    chk_read_fmt_bit0: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rdHit(req, amcr_pkg::ADDR_FMT_MODE) |=> rdData[0] == 1'b0)
        else $error("reserved format bit read as one");
    chk_read_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !req.rdStb |=> $stable(rdData))
        else $error("read data changed without a read");
endmodule // amcr_regs
`default_nettype wire

// ===== verif/amcr_host.sv
// Host model driving the register port of the mode register bank.
// Assumes a free running sys_clk; requests change 1 ns after a rising edge.
`default_nettype none
module amcr_host (
    input wire logic sys_clk, // Master clock
    output amcr_pkg::amcr_req_t req // Register port request
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    // One strobe cycle, then idle with scrambled address and data
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 req <= '{wrStb: wr, rdStb: !wr, addr: a, wdata: d};
        @(posedge sys_clk);
        #1 req <= '{wrStb: 1'b0, rdStb: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule // amcr_host
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the mode register bank.
// Assumes the host model drives the register port; read results checked from a queue.
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] volumeByteA, volumeByteB, rdData, volumeOutA, volumeOutB, v;
    logic coreClkEn;
    amcr_pkg::amcr_req_t req;
    amcr_pkg::amcr_cfg_t cfg;
    int n_errors = 0, n_checks = 0, cycles = 0, ens;
    logic [7:0] expq[$];
    logic [7:0] expRd;
    // Fixed 25 MHz clock standing for a supported stand-alone ratio
    always #20 sys_clk = ~sys_clk;
    amcr_host host (.sys_clk(sys_clk), .req(req));
    amcr_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .volumeByteA(volumeByteA),
        .volumeByteB(volumeByteB), .rdData(rdData), .coreClkEn(coreClkEn), .cfg(cfg),
        .volumeOutA(volumeOutA), .volumeOutB(volumeOutB));
    // Read results against the oldest note
    always @(posedge sys_clk) if (req.rdStb === 1'b1 && rst_n) begin
        expRd = expq.pop_front();
        #2 `CHK("rdData", expRd, rdData)
    end
    // Hang guard
    always @(posedge sys_clk) if (++cycles == 2000) begin
        n_errors++;
        complete_run();
    end
    task automatic complete_run();
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask
    task automatic wait2();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // Main sequence
    initial begin
        volumeByteA = 8'h00;
        volumeByteB = 8'h00;
        v = 8'($urandom(32'h5484));
        repeat (10) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        rd(8'h0a, 8'h00);
        rd(8'h0b, 8'h00);
        rd(8'h0c, {4'h0, amcr_pkg::REVISION_CODE});
        rd(8'h0d, 8'h00);
        host.access(1'b1, 8'h0c, 8'hff);
        rd(8'h0c, {4'h0, amcr_pkg::REVISION_CODE});
        // Every de-emphasis code at both speeds
        for (int i = 0; i < 8; i++) begin
            host.access(1'b1, 8'h0a, {1'b0, i[0], 1'b0, i[2], !i[2] & i[1] & i[0], !i[2] & (i[1] ^ i[0]), i[1:0]});
            wait2();
            `CHK("speed", i[2], cfg.doubleSpeedSelect)
            `CHK("deemph", i[2] ? 2'h0 : i[1:0], cfg.deemphasisSelect)
            `CHK("treble", !i[2], cfg.trebleAllowed)
            `CHK("ramp", !i[2], cfg.rampAllowed)
            `CHK("clockdivide", {i[0], 1'b0}, cfg.clockDivideSelect)
            `CHK("freqshift", i[2] ? 2'h0 : {i[1] & i[0], i[1] ^ i[0]}, cfg.frequencyShiftSelect)
        end
        // Every format code, volume link and bypass
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            volumeByteA = v;
            volumeByteB = ~v;
            host.access(1'b1, 8'h0b, {i[1:0], i[0], i[1], 2'h2, i[0], 1'b1});
            wait2();
            `CHK("format", i[1:0], cfg.serialFormatSelect)
            `CHK("bypass", i[1], cfg.volumePathBypass)
            `CHK("regctl", 1'b1, cfg.registerControlEnable)
            `CHK("hpsense", i[0], cfg.headphoneSenseEnable)
            `CHK("volA", v, volumeOutA)
            if (!i[1]) `CHK("volB", i[0] ? v : ~v, volumeOutB)
        end
        rd(8'h0b, 8'hfa);
        // Hold, change, release; halving then applied
        host.access(1'b1, 8'h0b, 8'h0c);
        host.access(1'b1, 8'h0a, 8'h80);
        wait2();
        `CHK("held", 1'b1, cfg.doubleSpeedSelect)
        `CHK("fmt held", 2'h3, cfg.serialFormatSelect)
        rd(8'h0a, 8'h80);
        host.access(1'b1, 8'h0b, 8'h08);
        wait2();
        `CHK("applied", 1'b0, cfg.doubleSpeedSelect)
        `CHK("fmt applied", 2'h0, cfg.serialFormatSelect)
        ens = 0;
        repeat (8) begin
            @(posedge sys_clk);
            #1 ens += coreClkEn;
        end
        `CHK("halve", 4, ens)
        // Reset in mid-run
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        rd(8'h0a, 8'h00);
        rd(8'h0b, 8'h00);
        `CHK("treble after reset", 1'b1, cfg.trebleAllowed)
        `CHK("enable after reset", 1'b1, coreClkEn)
        repeat (3) @(posedge sys_clk);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
